//--- ildiag_pkg.sv
package ildiag_pkg;
	localparam int ILD_ADDR_W = 16;
	localparam int ILD_DATA_W = 32;
	localparam int ILD_MAX_LANES = 32;
	localparam int ILD_CNT_W = 4;
	localparam logic [ILD_CNT_W-1:0] ILD_CNT_MAX = 4'hf;
	localparam logic [ILD_CNT_W-1:0] ILD_CNT_ONE = 4'h1;
	localparam logic [ILD_CNT_W-1:0] ILD_CNT_RST = 4'h0;
	localparam int ILD_LANES_PER_CNT_REG = 8;

	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_LOOPBACK = 16'h0012;
	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_DBG_RESET = 16'h0013;
	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_ALIGN = 16'h0020;
	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_BLOCK_LOCK = 16'h0021;
	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_MF_LOCK = 16'h0022;
	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_ERRCNT0 = 16'h0023;
	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_ERRCNT1 = 16'h0024;
	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_ERRCNT2 = 16'h0025;
	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_ERRCNT3 = 16'h0026;
	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_RX_LOST = 16'h0028;
	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_TX_LOST = 16'h0029;
	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_FAULT_INS = 16'h0038;
	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_TX_RDY = 16'h0040;
	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_RX_RDY = 16'h0041;
	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_XCODER = 16'h0080;
	localparam logic [ILD_ADDR_W-1:0] ILD_OFF_FEC_UNCOR = 16'h0081;

	localparam int ILD_DBG_LOCK_DATA_BIT = 9;
	localparam int ILD_DBG_LOCK_REF_BIT = 8;
	localparam int ILD_DBG_CLR_TX_BIT = 7;
	localparam int ILD_DBG_CLR_RX_BIT = 6;
	localparam int ILD_ALIGN_TX_BIT = 0;
	localparam int ILD_ALIGN_RX_BIT = 1;
	localparam int ILD_ALIGN_FEC_AM_BIT = 12;
	localparam int ILD_FLAG_BIT = 0;

	localparam logic [ILD_DATA_W-1:0] ILD_DATA_RST = 32'h0000_0000;
	localparam logic ILD_BIT_RST = 1'b0;
endpackage

//--- ildiag_sync2.sv
`timescale 1ns/100ps
module ildiag_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	import ildiag_pkg::*;

	logic [WIDTH-1:0] meta;

	// first stage feeds only the second one
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule // ildiag_sync2

//--- ildiag_errcnt.sv
`timescale 1ns/100ps
module ildiag_errcnt #(
	parameter int LANES = 32
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clr,
	input wire logic [LANES-1:0] err,
	output logic [ildiag_pkg::ILD_CNT_W*LANES-1:0] cnt_flat
);
	import ildiag_pkg::*;

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic [ILD_CNT_W-1:0] cnt;
			// clear wins over a same-cycle error: a counter is a tally, not a flag
			always_ff @(posedge mclk or posedge sys_rst) begin
				if (sys_rst) begin
					cnt <= ILD_CNT_RST;
				end else if (clr) begin
					cnt <= ILD_CNT_RST;
				end else if (err[g] && cnt != ILD_CNT_MAX) begin
					cnt <= cnt + ILD_CNT_ONE;
				end
			end
			assign cnt_flat[g*ILD_CNT_W +: ILD_CNT_W] = cnt;
		end
	endgenerate
endmodule // ildiag_errcnt

//--- ildiag_regs.sv
`timescale 1ns/100ps
// Contract
// - loopback register 0x12 holds one bit per lane, set bit loops lane back
// - alternate transceiver variant has no loopback control in this bank
// - debug reset bit 9 forces clock recovery to lock to data; the alternate variant holds cdr_force_lock_data at zero
// - debug reset bit 8 forces clock recovery to lock to reference; the alternate variant holds cdr_force_lock_ref at zero
// - debug reset bit 7 synchronously clears transmit counters and sticky flags
// - debug reset bit 6 synchronously clears receive counters, flags, crc counters
// - alignment register 0x20 shows tx aligned in bit 0, rx in bit 1
// - alignment bit 12 shows fec marker sync in pam4 alternate variant only
// - register 0x21 shows per-lane block boundary lock
// - register 0x22 shows per-lane metaframe lock
// - 4-bit crc error counter per lane, eight per register, 0x23 to 0x26
// - counters saturate at f and clear only by receive clear bit
// - 0x28 bit 0 sticky on receive alignment loss until cleared
// - 0x29 bit 0 sticky on transmit alignment loss until cleared
// - register 0x38 per-lane bit corrupts that lane's transmitted crc32
// - alternate variant 0x40 shows per-lane transmit channel ready
// - alternate variant 0x41 shows per-lane receive channel ready
// - pam4 alternate 0x80 flags bad transcoder framing, write zero clears
// - pam4 alternate 0x81 flags uncorrectable fec codeword, write zero clears
// - reset returns every loopback bit to zero
module ildiag_regs #(
	parameter int NUM_LANES = 32,
	parameter bit ALT_XCVR = 1'b0,
	parameter bit PAM4_MODE = 1'b0
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [ildiag_pkg::ILD_ADDR_W-1:0] reg_addr,
	input wire logic [ildiag_pkg::ILD_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ildiag_pkg::ILD_DATA_W-1:0] reg_rdata,
	input wire logic tx_lanes_aligned,
	input wire logic rx_lanes_aligned,
	input wire logic fec_am_locked,
	input wire logic [NUM_LANES-1:0] rx_block_locked,
	input wire logic [NUM_LANES-1:0] rx_metaframe_locked,
	input wire logic [NUM_LANES-1:0] tx_chan_ready,
	input wire logic [NUM_LANES-1:0] rx_chan_ready,
	input wire logic [NUM_LANES-1:0] rx_crc_fail,
	input wire logic rx_align_lost_evt,
	input wire logic tx_align_lost_evt,
	input wire logic xcoder_bad_framing_evt,
	input wire logic fec_uncor_evt,
	output logic [NUM_LANES-1:0] serial_loopback,
	output logic cdr_force_lock_data,
	output logic cdr_force_lock_ref,
	output logic clear_tx_errors,
	output logic clear_rx_errors,
	output logic [NUM_LANES-1:0] tx_crc_corrupt
);
	import ildiag_pkg::*;

	localparam int STAT_W = 3 + 4 * NUM_LANES;
	localparam bit HAS_FEC = ALT_XCVR && PAM4_MODE;
	// the top lane is the one the bench drives into saturation
	localparam int TOP_LSB = (NUM_LANES - 1) * ILD_CNT_W;

	logic [STAT_W-1:0] stat_raw;
	logic [STAT_W-1:0] stat_sync;
	logic tx_al_s;
	logic rx_al_s;
	logic fec_am_s;
	logic [NUM_LANES-1:0] blk_s;
	logic [NUM_LANES-1:0] mf_s;
	logic [NUM_LANES-1:0] txrdy_s;
	logic [NUM_LANES-1:0] rxrdy_s;
	logic [ILD_CNT_W*NUM_LANES-1:0] crc_flat;
	logic [ILD_CNT_W*ILD_MAX_LANES-1:0] crc_all;
	logic rx_lost;
	logic tx_lost;
	logic xcoder_flag;
	logic fec_flag;
	logic wr_lb;
	logic wr_dbg;
	logic wr_fault;
	logic wr_xcoder;
	logic wr_fec;
	logic mapped;
	logic [ILD_DATA_W-1:0] next_rdata;

	function automatic logic hit(input logic [ILD_ADDR_W-1:0] a,
			input logic [ILD_ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// lanes beyond the configured count read as zero
	function automatic logic [ILD_DATA_W-1:0] pad_lanes(input logic [NUM_LANES-1:0] v);
		pad_lanes = '0;
		pad_lanes[NUM_LANES-1:0] = v;
	endfunction

	// status levels come from the lane clocks, so they are resynchronised here
	assign stat_raw = {tx_lanes_aligned, rx_lanes_aligned, fec_am_locked,
		rx_block_locked, rx_metaframe_locked, tx_chan_ready, rx_chan_ready};

	ildiag_sync2 #(
		.WIDTH(STAT_W)
	) u_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.async_in(stat_raw),
		.sync_out(stat_sync)
	);

	assign {tx_al_s, rx_al_s, fec_am_s, blk_s, mf_s, txrdy_s, rxrdy_s} = stat_sync;

	ildiag_errcnt #(
		.LANES(NUM_LANES)
	) u_errcnt (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clr(clear_rx_errors),
		.err(rx_crc_fail),
		.cnt_flat(crc_flat)
	);

	always_comb begin
		crc_all = '0;
		crc_all[ILD_CNT_W*NUM_LANES-1:0] = crc_flat;
	end

	assign wr_lb = reg_wr && hit(reg_addr, ILD_OFF_LOOPBACK);
	assign wr_dbg = reg_wr && hit(reg_addr, ILD_OFF_DBG_RESET);
	assign wr_fault = reg_wr && hit(reg_addr, ILD_OFF_FAULT_INS);
	assign wr_xcoder = reg_wr && hit(reg_addr, ILD_OFF_XCODER);
	assign wr_fec = reg_wr && hit(reg_addr, ILD_OFF_FEC_UNCOR);

	// loopback: the alternate transceiver loops back through its own registers
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			serial_loopback <= '0;
		end else if (wr_lb && !ALT_XCVR) begin
			serial_loopback <= reg_wdata[NUM_LANES-1:0];
		end
	end

	// debug reset: the clear bits act for as long as software leaves them set
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cdr_force_lock_data <= ILD_BIT_RST;
			cdr_force_lock_ref <= ILD_BIT_RST;
			clear_tx_errors <= ILD_BIT_RST;
			clear_rx_errors <= ILD_BIT_RST;
		end else if (wr_dbg) begin
			cdr_force_lock_data <= !ALT_XCVR && reg_wdata[ILD_DBG_LOCK_DATA_BIT];
			cdr_force_lock_ref <= !ALT_XCVR && reg_wdata[ILD_DBG_LOCK_REF_BIT];
			clear_tx_errors <= reg_wdata[ILD_DBG_CLR_TX_BIT];
			clear_rx_errors <= reg_wdata[ILD_DBG_CLR_RX_BIT];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_crc_corrupt <= '0;
		end else if (wr_fault) begin
			tx_crc_corrupt <= reg_wdata[NUM_LANES-1:0];
		end
	end

	// sticky flags: a new event in the clearing cycle keeps the flag set
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_lost <= ILD_BIT_RST;
		end else if (rx_align_lost_evt) begin
			rx_lost <= 1'b1;
		end else if (clear_rx_errors) begin
			rx_lost <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_lost <= ILD_BIT_RST;
		end else if (tx_align_lost_evt) begin
			tx_lost <= 1'b1;
		end else if (clear_tx_errors) begin
			tx_lost <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			xcoder_flag <= ILD_BIT_RST;
		end else if (!HAS_FEC) begin
			xcoder_flag <= 1'b0;
		end else if (xcoder_bad_framing_evt) begin
			xcoder_flag <= 1'b1;
		end else if (wr_xcoder && !reg_wdata[ILD_FLAG_BIT]) begin
			xcoder_flag <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			fec_flag <= ILD_BIT_RST;
		end else if (!HAS_FEC) begin
			fec_flag <= 1'b0;
		end else if (fec_uncor_evt) begin
			fec_flag <= 1'b1;
		end else if (wr_fec && !reg_wdata[ILD_FLAG_BIT]) begin
			fec_flag <= 1'b0;
		end
	end

	// read decode, presented one cycle after the strobe
	always_comb begin
		next_rdata = ILD_DATA_RST;
		mapped = 1'b1;
		unique case (reg_addr)
			ILD_OFF_LOOPBACK: next_rdata = pad_lanes(serial_loopback);
			ILD_OFF_DBG_RESET: begin
				next_rdata[ILD_DBG_LOCK_DATA_BIT] = cdr_force_lock_data;
				next_rdata[ILD_DBG_LOCK_REF_BIT] = cdr_force_lock_ref;
				next_rdata[ILD_DBG_CLR_TX_BIT] = clear_tx_errors;
				next_rdata[ILD_DBG_CLR_RX_BIT] = clear_rx_errors;
			end
			ILD_OFF_ALIGN: begin
				next_rdata[ILD_ALIGN_TX_BIT] = tx_al_s;
				next_rdata[ILD_ALIGN_RX_BIT] = rx_al_s;
				next_rdata[ILD_ALIGN_FEC_AM_BIT] = HAS_FEC && fec_am_s;
			end
			ILD_OFF_BLOCK_LOCK: next_rdata = pad_lanes(blk_s);
			ILD_OFF_MF_LOCK: next_rdata = pad_lanes(mf_s);
			ILD_OFF_ERRCNT0: next_rdata = crc_all[0 +: ILD_DATA_W];
			ILD_OFF_ERRCNT1: next_rdata = crc_all[ILD_DATA_W +: ILD_DATA_W];
			ILD_OFF_ERRCNT2: next_rdata = crc_all[2*ILD_DATA_W +: ILD_DATA_W];
			ILD_OFF_ERRCNT3: next_rdata = crc_all[3*ILD_DATA_W +: ILD_DATA_W];
			ILD_OFF_RX_LOST: next_rdata[ILD_FLAG_BIT] = rx_lost;
			ILD_OFF_TX_LOST: next_rdata[ILD_FLAG_BIT] = tx_lost;
			ILD_OFF_FAULT_INS: next_rdata = pad_lanes(tx_crc_corrupt);
			ILD_OFF_TX_RDY: next_rdata = ALT_XCVR ? pad_lanes(txrdy_s) : ILD_DATA_RST;
			ILD_OFF_RX_RDY: next_rdata = ALT_XCVR ? pad_lanes(rxrdy_s) : ILD_DATA_RST;
			ILD_OFF_XCODER: next_rdata[ILD_FLAG_BIT] = xcoder_flag;
			ILD_OFF_FEC_UNCOR: next_rdata[ILD_FLAG_BIT] = fec_flag;
			default: mapped = 1'b0;
		endcase
	end

	// data holds only in the cycle after a read; zero otherwise keeps the bus quiet
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= ILD_DATA_RST;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= ILD_DATA_RST;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	a_loopback_write: assert property (wr_lb |=>
		serial_loopback == (ALT_XCVR ? '0 : $past(reg_wdata[NUM_LANES-1:0])))
		else $error("loopback bits do not follow the write");

	a_alt_no_loopback: assert property (!ALT_XCVR || serial_loopback == '0)
		else $error("loopback set in alternate transceiver variant");

	a_lock_data_bit: assert property (wr_dbg |=>
		cdr_force_lock_data == (!ALT_XCVR && $past(reg_wdata[ILD_DBG_LOCK_DATA_BIT])))
		else $error("lock to data control wrong after write");

	a_lock_ref_bit: assert property (wr_dbg |=>
		cdr_force_lock_ref == (!ALT_XCVR && $past(reg_wdata[ILD_DBG_LOCK_REF_BIT])))
		else $error("lock to reference control wrong after write");

	a_tx_flag_clear: assert property (clear_tx_errors && !tx_align_lost_evt |=> !tx_lost)
		else $error("tx sticky flag survived clear");

	a_rx_count_clear: assert property (clear_rx_errors |=> crc_flat == '0 &&
		(rx_lost == $past(rx_align_lost_evt)))
		else $error("rx counters or flag survived clear");

	a_align_readback: assert property (reg_rd && hit(reg_addr, ILD_OFF_ALIGN) |=>
		reg_rdata[ILD_ALIGN_RX_BIT] == $past(rx_al_s) &&
		reg_rdata[ILD_ALIGN_TX_BIT] == $past(tx_al_s))
		else $error("alignment readback mismatch");

	a_crc_increment: assert property (rx_crc_fail[0] && !clear_rx_errors &&
		crc_flat[ILD_CNT_W-1:0] != ILD_CNT_MAX |=>
		crc_flat[ILD_CNT_W-1:0] == $past(crc_flat[ILD_CNT_W-1:0]) + ILD_CNT_ONE)
		else $error("crc counter missed a failure");

	a_crc_saturate: assert property (crc_flat[TOP_LSB +: ILD_CNT_W] == ILD_CNT_MAX &&
		!clear_rx_errors |=> crc_flat[TOP_LSB +: ILD_CNT_W] == ILD_CNT_MAX)
		else $error("crc counter left saturation without clear");

	a_fec_am_readback: assert property (reg_rd && hit(reg_addr, ILD_OFF_ALIGN) |=>
		reg_rdata[ILD_ALIGN_FEC_AM_BIT] == (HAS_FEC && $past(fec_am_s)))
		else $error("fec marker sync readback mismatch");

	a_block_readback: assert property (reg_rd && hit(reg_addr, ILD_OFF_BLOCK_LOCK) |=>
		reg_rdata[NUM_LANES-1:0] == $past(blk_s))
		else $error("block boundary readback mismatch");

	a_mframe_readback: assert property (reg_rd && hit(reg_addr, ILD_OFF_MF_LOCK) |=>
		reg_rdata[NUM_LANES-1:0] == $past(mf_s))
		else $error("metaframe lock readback mismatch");

	a_txrdy_readback: assert property (reg_rd && hit(reg_addr, ILD_OFF_TX_RDY) |=>
		reg_rdata[NUM_LANES-1:0] == (ALT_XCVR ? $past(txrdy_s) : '0))
		else $error("tx channel ready readback mismatch");

	a_rxrdy_readback: assert property (reg_rd && hit(reg_addr, ILD_OFF_RX_RDY) |=>
		reg_rdata[NUM_LANES-1:0] == (ALT_XCVR ? $past(rxrdy_s) : '0))
		else $error("rx channel ready readback mismatch");

	a_xcoder_flag_set: assert property (xcoder_bad_framing_evt |=> xcoder_flag == HAS_FEC)
		else $error("transcoder flag not set by event");

	a_xcoder_flag_clear: assert property (wr_xcoder && !reg_wdata[ILD_FLAG_BIT] &&
		!xcoder_bad_framing_evt |=> !xcoder_flag)
		else $error("transcoder flag not cleared by zero write");

	a_tx_lost_sticky: assert property (tx_lost && !clear_tx_errors |=> tx_lost)
		else $error("tx alignment loss flag not held");

	a_rx_lost_sticky: assert property (rx_align_lost_evt ##1 !clear_rx_errors[*2] |->
		rx_lost)
		else $error("rx alignment loss flag not held");

	a_tx_lost_set: assert property (tx_align_lost_evt |=> tx_lost)
		else $error("tx alignment loss flag not set");

	a_inject_write: assert property (wr_fault |=>
		tx_crc_corrupt == $past(reg_wdata[NUM_LANES-1:0]))
		else $error("injection bits do not follow the write");

	a_fec_flag_clear: assert property (wr_fec && !reg_wdata[ILD_FLAG_BIT] &&
		!fec_uncor_evt |=> !fec_flag)
		else $error("fec flag not cleared by zero write");

	a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == '0)
		else $error("unmapped read returned nonzero");

	c_loopback_on: cover property (wr_lb ##1 serial_loopback != '0);
	c_crc_saturated: cover property (crc_flat[TOP_LSB +: ILD_CNT_W] == ILD_CNT_MAX);
	c_fec_cleared: cover property (fec_flag ##1 wr_fec ##1 !fec_flag);
	c_rx_lost_cleared: cover property (rx_lost ##1 clear_rx_errors ##1 !rx_lost);
	c_inject_on: cover property (wr_fault ##1 tx_crc_corrupt != '0);
endmodule // ildiag_regs

//--- ildiag_regs_tb.sv
`timescale 1ns/100ps
module ildiag_regs_tb;
	import ildiag_pkg::*;
	localparam int NL = 24;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] addr = '0;
	logic [31:0] wd = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic txal = 1'b0;
	logic rxal = 1'b0;
	logic fecam = 1'b0;
	logic [NL-1:0] blk = '0;
	logic [NL-1:0] mfl = '0;
	logic [NL-1:0] txr = '0;
	logic [NL-1:0] rxr = '0;
	logic [NL-1:0] crcf = '0;
	logic rxlost = 1'b0;
	logic txlost = 1'b0;
	logic xbad = 1'b0;
	logic fecu = 1'b0;
	logic [31:0] rdm, rda;
	logic [NL-1:0] lbm, lba, injm, inja;
	logic ldm, lda, lrm, lra, ctm, cta, crm, cra;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;

	always #4 mclk = ~mclk;

	// lane count below 32 so the unused upper lanes are exercised
	ildiag_regs #(.NUM_LANES(NL)) ildiag_regs_i (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(addr),
		.reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdm), .tx_lanes_aligned(txal),
		.rx_lanes_aligned(rxal), .fec_am_locked(fecam), .rx_block_locked(blk),
		.rx_metaframe_locked(mfl), .tx_chan_ready(txr), .rx_chan_ready(rxr), .rx_crc_fail(crcf),
		.rx_align_lost_evt(rxlost), .tx_align_lost_evt(txlost), .xcoder_bad_framing_evt(xbad),
		.fec_uncor_evt(fecu), .serial_loopback(lbm), .cdr_force_lock_data(ldm),
		.cdr_force_lock_ref(lrm), .clear_tx_errors(ctm), .clear_rx_errors(crm),
		.tx_crc_corrupt(injm));
	// second build shares all stimulus; it is the only way to reach the gated registers
	ildiag_regs #(.NUM_LANES(NL), .ALT_XCVR(1'b1), .PAM4_MODE(1'b1)) ildiag_regs_alt_i (
		.mclk(mclk), .sys_rst(sys_rst), .reg_addr(addr),
		.reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rda), .tx_lanes_aligned(txal),
		.rx_lanes_aligned(rxal), .fec_am_locked(fecam), .rx_block_locked(blk),
		.rx_metaframe_locked(mfl), .tx_chan_ready(txr), .rx_chan_ready(rxr), .rx_crc_fail(crcf),
		.rx_align_lost_evt(rxlost), .tx_align_lost_evt(txlost), .xcoder_bad_framing_evt(xbad),
		.fec_uncor_evt(fecu), .serial_loopback(lba), .cdr_force_lock_data(lda),
		.cdr_force_lock_ref(lra), .clear_tx_errors(cta), .clear_rx_errors(cra),
		.tx_crc_corrupt(inja));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks=%0d errors=%0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic do_reset();
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		#1;
	endtask

	task automatic wreg(input logic [15:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		#1;
	endtask

	// read data stands one cycle only, so both builds are sampled just after that edge
	task automatic rreg(input logic [15:0] a, input logic [31:0] em, input logic [31:0] ea);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(rdm, em);
		chk(rda, ea);
	endtask

	task automatic crc_burst(input logic [NL-1:0] m, input int n);
		@(posedge mclk);
		crcf <= m;
		repeat (n) @(posedge mclk);
		crcf <= '0;
	endtask

	task automatic t_reset();
		rreg(ILD_OFF_LOOPBACK, 32'h0, 32'h0);
		rreg(ILD_OFF_DBG_RESET, 32'h0, 32'h0);
		chk(32'(lbm), 32'h0);
	endtask

	task automatic t_loop();
		wreg(ILD_OFF_LOOPBACK, 32'hffff_ffff);
		chk(32'(lbm), 32'h00ff_ffff);
		chk(32'(lba), 32'h0);
		rreg(ILD_OFF_LOOPBACK, 32'h00ff_ffff, 32'h0);
		wreg(ILD_OFF_LOOPBACK, 32'h0000_0005);
		chk(32'(lbm), 32'h5);
		do_reset();
		chk(32'(lbm), 32'h0);
	endtask

	task automatic t_dbg();
		wreg(ILD_OFF_DBG_RESET, 32'h0000_0200);
		chk(32'({ldm, lrm, lda, lra}), 32'h8);
		wreg(ILD_OFF_DBG_RESET, 32'h0000_0100);
		chk(32'({ldm, lrm, lda, lra}), 32'h4);
		rreg(ILD_OFF_DBG_RESET, 32'h100, 32'h0);
		wreg(ILD_OFF_DBG_RESET, 32'hffff_fc3f);
		rreg(ILD_OFF_DBG_RESET, 32'h0, 32'h0);
	endtask

	task automatic t_status();
		@(posedge mclk);
		txal <= 1'b1;
		fecam <= 1'b1;
		blk <= 24'h12_3456;
		mfl <= 24'hab_cdef;
		txr <= 24'h0f_0f0f;
		rxr <= 24'hf0_f0f0;
		repeat (3) @(posedge mclk);
		rreg(ILD_OFF_ALIGN, 32'h1, 32'h1001);
		rreg(ILD_OFF_BLOCK_LOCK, 32'h12_3456, 32'h12_3456);
		rreg(ILD_OFF_MF_LOCK, 32'hab_cdef, 32'hab_cdef);
		rreg(ILD_OFF_TX_RDY, 32'h0, 32'h0f_0f0f);
		rreg(ILD_OFF_RX_RDY, 32'h0, 32'hf0_f0f0);
		@(posedge mclk);
		txal <= 1'b0;
		rxal <= 1'b1;
		fecam <= 1'b0;
		repeat (3) @(posedge mclk);
		rreg(ILD_OFF_ALIGN, 32'h2, 32'h2);
	endtask

	task automatic t_crc();
		crc_burst(24'h80_0201, 1);
		crc_burst(24'h80_0200, 2);
		crc_burst(24'h80_0000, 17);
		@(posedge mclk);
		rxlost <= 1'b1;
		@(posedge mclk);
		rxlost <= 1'b0;
		rreg(ILD_OFF_ERRCNT0, 32'h1, 32'h1);
		rreg(ILD_OFF_ERRCNT1, 32'h30, 32'h30);
		rreg(ILD_OFF_ERRCNT2, 32'hf000_0000, 32'hf000_0000);
		rreg(ILD_OFF_ERRCNT3, 32'h0, 32'h0);
		repeat (5) @(posedge mclk);
		rreg(ILD_OFF_RX_LOST, 32'h1, 32'h1);
		wreg(ILD_OFF_DBG_RESET, 32'h40);
		chk(32'({crm, cra, ctm, cta}), 32'hc);
		crc_burst(24'h00_0001, 2);
		rreg(ILD_OFF_ERRCNT0, 32'h0, 32'h0);
		rreg(ILD_OFF_ERRCNT2, 32'h0, 32'h0);
		rreg(ILD_OFF_RX_LOST, 32'h0, 32'h0);
		wreg(ILD_OFF_DBG_RESET, 32'h0);
		crc_burst(24'h00_0001, 1);
		rreg(ILD_OFF_ERRCNT0, 32'h1, 32'h1);
	endtask

	task automatic t_tx();
		crc_burst(24'h00_0001, 2);
		@(posedge mclk);
		txlost <= 1'b1;
		@(posedge mclk);
		txlost <= 1'b0;
		repeat (4) @(posedge mclk);
		rreg(ILD_OFF_TX_LOST, 32'h1, 32'h1);
		wreg(ILD_OFF_DBG_RESET, 32'h80);
		chk(32'({ctm, cta, crm}), 32'h6);
		rreg(ILD_OFF_TX_LOST, 32'h0, 32'h0);
		rreg(ILD_OFF_ERRCNT0, 32'h3, 32'h3);
		wreg(ILD_OFF_DBG_RESET, 32'h0);
	endtask

	task automatic t_inj();
		wreg(ILD_OFF_FAULT_INS, 32'ha5a5_a5a5);
		chk(32'(injm), 32'ha5_a5a5);
		chk(32'(inja), 32'ha5_a5a5);
		repeat (8) @(posedge mclk);
		chk(32'(injm), 32'ha5_a5a5);
		rreg(ILD_OFF_FAULT_INS, 32'ha5_a5a5, 32'ha5_a5a5);
		wreg(ILD_OFF_FAULT_INS, 32'h0);
		chk(32'(injm), 32'h0);
		chk(32'(inja), 32'h0);
	endtask

	task automatic t_fec();
		@(posedge mclk);
		xbad <= 1'b1;
		fecu <= 1'b1;
		@(posedge mclk);
		xbad <= 1'b0;
		fecu <= 1'b0;
		rreg(ILD_OFF_XCODER, 32'h0, 32'h1);
		rreg(ILD_OFF_FEC_UNCOR, 32'h0, 32'h1);
		wreg(ILD_OFF_XCODER, 32'h1);
		rreg(ILD_OFF_XCODER, 32'h0, 32'h1);
		wreg(ILD_OFF_XCODER, 32'h0);
		rreg(ILD_OFF_XCODER, 32'h0, 32'h0);
		wreg(ILD_OFF_FEC_UNCOR, 32'h0);
		rreg(ILD_OFF_FEC_UNCOR, 32'h0, 32'h0);
		rreg(16'h0030, 32'h0, 32'h0);
		wreg(ILD_OFF_ALIGN, 32'hffff_ffff);
		rreg(ILD_OFF_ALIGN, 32'h2, 32'h2);
	endtask

	// whole run needs well under a thousand cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			conclude();
		end
	end

	initial begin
		do_reset();
		t_reset();
		t_loop();
		t_dbg();
		t_status();
		t_crc();
		t_tx();
		t_inj();
		t_fec();
		conclude();
	end
endmodule // ildiag_regs_tb
